/* rtl/scg_pkg.sv */
// package for the system clock generation block
// assumes a single 25 MHz system clock; oscillators arrive as sampled levels
package scg_pkg;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned GATE_W      = 17;
  localparam int unsigned DIV_W       = 8;
  localparam int unsigned WAKE_N      = 11;
  localparam logic [16:0] GATE_RST    = 17'h0085f;
  localparam logic [7:0]  DIV_RST     = 8'h00;
  localparam logic [1:0]  SEL_RST     = 2'h0;

  // ----------------------------------------------------------------
  // clock source encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SCG_MAIN_RC   = 2'h0,
    SCG_MAIN_PLLI = 2'h1,
    SCG_MAIN_WDO  = 2'h2,
    SCG_MAIN_PLLO = 2'h3
  } scg_main_sel_t;

  typedef enum logic [1:0] {
    SCG_OBS_RC   = 2'h0,
    SCG_OBS_SYS  = 2'h1,
    SCG_OBS_WDO  = 2'h2,
    SCG_OBS_MAIN = 2'h3
  } scg_obs_sel_t;

  // switch sequence: gray coded from run through drain to load; load back to run flips both bits
  typedef enum logic [1:0] {
    SCG_SW_RUN  = 2'b00,
    SCG_SW_DRAIN = 2'b01,
    SCG_SW_LOAD = 2'b11
  } scg_sw_state_t;

  // ----------------------------------------------------------------
  // configuration carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic          pll_src_sys;
    scg_main_sel_t main_sel;
    scg_obs_sel_t  obs_sel;
    logic [7:0]    uart_div;
    logic [7:0]    wd_div;
    logic [7:0]    ssp_div;
    logic [7:0]    obs_div;
    logic [16:0]   gate;
  } scg_cfg_t;

endpackage : scg_pkg

/* rtl/scg_clock_gen.sv */
// system clock generation: source select, gating, dividers, wake logic
// assumes oscillator inputs are slow levels from other domains; the
// configuration comes from logic on clk_i
//
// Contract
// - after reset the main clock runs from the internal rc oscillator
// - software picks system or internal rc oscillator as pll input
// - one software enable per peripheral or memory gates its clock
// - uart, watchdog and serial port clocks each have own divider
// - observation pin shows main, rc, system or watchdog clock
// - observed clock passes a programmable divider before the pin
// - up to eleven port pins wake the processor from deep sleep
`timescale 1ns/1ps
`default_nettype none
module scg_clock_gen
  import scg_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire scg_cfg_t          cfg_i,
  input  wire logic              cfg_upd_i,
  input  wire logic              rc_osc_i,
  input  wire logic              sys_osc_i,
  input  wire logic              wd_osc_i,
  input  wire logic              pll_out_i,
  input  wire logic [WAKE_N-1:0] wakeup_input_pins_i,
  input  wire logic [WAKE_N-1:0] wake_en_i,
  input  wire logic              deep_sleep_i,
  output logic                   pll_in_o,
  output logic                   main_clk_o,
  output logic [GATE_W-1:0]      gated_clk_o,
  output logic                   uart_clk_o,
  output logic                   wd_clk_o,
  output logic                   ssp_clk_o,
  output logic                   clock_observation_pin_o,
  output logic                   wake_o
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // the pll output is another clock's domain, so it is sampled as well
  logic [4+WAKE_N-1:0] sync1_q, sync1_d;
  logic [4+WAKE_N-1:0] sync2_q, sync2_d;
  logic rc_s, sys_s, wdo_s, pll_s;
  logic [WAKE_N-1:0] pin_s;

  always_comb
  begin
    sync1_d = {wakeup_input_pins_i, pll_out_i, wd_osc_i, sys_osc_i,
               rc_osc_i};
    sync2_d = sync1_q;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  assign rc_s  = sync2_q[0];
  assign sys_s = sync2_q[1];
  assign wdo_s = sync2_q[2];
  assign pll_s = sync2_q[3];
  assign pin_s = sync2_q[4+WAKE_N-1:4];

  // ----------------------------------------------------------------
  // shadow configuration and safe switch sequence
  // ----------------------------------------------------------------
  // new settings load one cycle after every divided clock and main are seen
  // low, so an output rising in that cycle can be cut short; waiting can take one full divided period
  scg_sw_state_t sw_q, sw_d;
  scg_cfg_t      act_q, act_d;
  scg_cfg_t      pend_q, pend_d;
  logic          all_low;

  always_comb
  begin
    sw_d   = sw_q;
    act_d  = act_q;
    pend_d = pend_q;
    case (sw_q)
      SCG_SW_RUN:
      begin
        if (cfg_upd_i)
        begin
          pend_d = cfg_i;
          sw_d   = SCG_SW_DRAIN;
        end
      end
      SCG_SW_DRAIN:
      begin
        if (all_low)
          sw_d = SCG_SW_LOAD;
      end
      SCG_SW_LOAD:
      begin
        act_d = pend_q;
        sw_d  = SCG_SW_RUN;
      end
      default:
        sw_d = SCG_SW_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sw_q <= SCG_SW_RUN;
      act_q <= '{pll_src_sys: 1'b0, main_sel: SCG_MAIN_RC,
                 obs_sel: SCG_OBS_RC, uart_div: DIV_RST,
                 wd_div: DIV_RST, ssp_div: DIV_RST,
                 obs_div: DIV_RST, gate: GATE_RST};
      pend_q <= '{pll_src_sys: 1'b0, main_sel: SCG_MAIN_RC,
                  obs_sel: SCG_OBS_RC, uart_div: DIV_RST,
                  wd_div: DIV_RST, ssp_div: DIV_RST,
                  obs_div: DIV_RST, gate: GATE_RST};
    end
    else
    begin
      sw_q   <= sw_d;
      act_q  <= act_d;
      pend_q <= pend_d;
    end
  end

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  logic main_src, obs_src;

  // pll input mux
  // a clock path to the pll, so it passes unsampled
  assign pll_in_o = act_q.pll_src_sys ? sys_osc_i : rc_osc_i;

  always_comb
  begin
    case (act_q.main_sel)
      SCG_MAIN_RC:   main_src = rc_s;
      SCG_MAIN_PLLI: main_src = act_q.pll_src_sys ? sys_s : rc_s;
      SCG_MAIN_WDO:  main_src = wdo_s;
      SCG_MAIN_PLLO: main_src = pll_s;
      default:       main_src = rc_s;
    endcase
  end

  // ----------------------------------------------------------------
  // dividers: zero stops the clock, n divides by 2n
  // ----------------------------------------------------------------
  logic [7:0] cnt_q [4];
  logic [7:0] cnt_d [4];
  logic [3:0] dclk_q, dclk_d;
  logic [3:0] src_v;
  logic [7:0] div_v [4];
  logic       main_q, main_d;
  logic       main_rise;

  always_comb
  begin
    case (act_q.obs_sel)
      SCG_OBS_RC:   obs_src = rc_s;
      SCG_OBS_SYS:  obs_src = sys_s;
      SCG_OBS_WDO:  obs_src = wdo_s;
      SCG_OBS_MAIN: obs_src = main_src;
      default:      obs_src = rc_s;
    endcase
  end

  assign main_d    = main_src;
  assign main_rise = main_src & ~main_q;
  assign div_v[0]  = act_q.uart_div;
  assign div_v[1]  = act_q.wd_div;
  assign div_v[2]  = act_q.ssp_div;
  assign div_v[3]  = act_q.obs_div;

  logic obs_q, obs_rise;
  assign obs_rise = obs_src & ~obs_q;
  assign src_v    = {obs_rise, main_rise, main_rise, main_rise};

  always_comb
  begin
    dclk_d = dclk_q;
    for (int i = 0; i < 4; i++)
    begin
      cnt_d[i] = cnt_q[i];
      if (div_v[i] == 8'h00)
      begin
        cnt_d[i]  = 8'h00;
        dclk_d[i] = 1'b0;
      end
      else if (src_v[i])
      begin
        if (cnt_q[i] >= div_v[i] - 8'h01)
        begin
          cnt_d[i]  = 8'h00;
          dclk_d[i] = ~dclk_q[i];
        end
        else
          cnt_d[i] = cnt_q[i] + 8'h01;
      end
    end
  end

  assign all_low = ~|dclk_q & ~main_q;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      for (int i = 0; i < 4; i++)
        cnt_q[i] <= 8'h00;
      dclk_q <= 4'h0;
      main_q <= 1'b0;
      obs_q  <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      dclk_q <= dclk_d;
      main_q <= main_d;
      obs_q  <= obs_src;
    end
  end

  // ----------------------------------------------------------------
  // gating and wake logic
  // ----------------------------------------------------------------
  logic       wake_q, wake_d;
  logic [GATE_W-1:0] gate_q, gate_d;

  // gate enables
  // enables change only while main is low, so pulses stay whole
  assign gate_d = main_q ? gate_q : act_q.gate;

  assign wake_d = deep_sleep_i & |(pin_s & wake_en_i);

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      gate_q <= GATE_RST;
      wake_q <= 1'b0;
    end
    else
    begin
      gate_q <= gate_d;
      wake_q <= wake_d;
    end
  end

  assign clock_observation_pin_o = dclk_q[3];
  assign main_clk_o  = main_q;
  assign gated_clk_o = {GATE_W{main_q}} & gate_q;
  assign uart_clk_o  = dclk_q[0];
  assign wd_clk_o    = dclk_q[1];
  assign ssp_clk_o   = dclk_q[2];
  assign wake_o      = wake_q;

endmodule : scg_clock_gen
`default_nettype wire

/* testbench/scg_edge_model.sv */
// model of the units fed by generated clocks: counts rising edges
// assumes each clock stays high across at least one clk_i edge
`timescale 1ns/1ps
`default_nettype none
module scg_edge_model #(
  parameter int N = 1
) (
  input  wire logic             clk_i,
  input  wire logic [N-1:0]       clks_i,
  output wire logic [N-1:0][15:0] cnt_o
);
  logic [N-1:0]       prev_q = '0;
  logic [N-1:0][15:0] cnt_q  = '0;
  assign cnt_o = cnt_q;
  always @(posedge clk_i)
  begin
    prev_q <= clks_i;
    for (int i = 0; i < N; i++)
      if (clks_i[i] && !prev_q[i])
        cnt_q[i] <= cnt_q[i] + 16'h1;
  end
endmodule : scg_edge_model
`default_nettype wire

/* testbench/scg_clock_gen_chk.sv */
// checker for the clock generation ports
// assumes oscillators slower than clk_i/2, as the design requires
`timescale 1ns/1ps
`default_nettype none
module scg_clock_gen_chk
  import scg_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              resetn_i,
  input wire logic              cfg_upd_i,
  input wire logic              rc_osc_i,
  input wire logic              pll_in_o,
  input wire logic [WAKE_N-1:0] wakeup_input_pins_i,
  input wire logic [WAKE_N-1:0] wake_en_i,
  input wire logic              deep_sleep_i,
  input wire logic              main_clk_o,
  input wire logic [GATE_W-1:0] gated_clk_o,
  input wire logic              uart_clk_o,
  input wire logic              clock_observation_pin_o,
  input wire logic              wake_o
);
  // set by the first update: reset settings hold until then
  logic upd_q;
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
      upd_q <= 1'b0;
    else if (cfg_upd_i)
      upd_q <= 1'b1;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  property p_rst_low;
    $rose(resetn_i) |-> !main_clk_o && gated_clk_o == '0 && !wake_o;
  endproperty
  a_rst_low: assert property (p_rst_low) else $error("reset out");
  property p_main_rst;
    !upd_q && $past(resetn_i, 3) |-> main_clk_o == $past(rc_osc_i, 3);
  endproperty
  a_main_rst: assert property (p_main_rst) else $error("main rc");
  property p_pll_rst;
    !upd_q |-> pll_in_o == rc_osc_i;
  endproperty
  a_pll_rst: assert property (p_pll_rst) else $error("pll in");
  property p_gate_main;
    (gated_clk_o & ~{GATE_W{main_clk_o}}) == '0;
  endproperty
  a_gate_main: assert property (p_gate_main) else $error("gate");
  property p_gate_rst;
    !upd_q |-> (gated_clk_o & ~GATE_RST) == '0;
  endproperty
  a_gate_rst: assert property (p_gate_rst) else $error("gate rst");
  property p_div_idle;
    !upd_q |-> !uart_clk_o && !clock_observation_pin_o;
  endproperty
  a_div_idle: assert property (p_div_idle) else $error("div 0");
  property p_uart_hi;
    $rose(uart_clk_o) |=> uart_clk_o;
  endproperty
  a_uart_hi: assert property (p_uart_hi) else $error("uart");
  property p_obs_hi;
    $rose(clock_observation_pin_o) |=> clock_observation_pin_o;
  endproperty
  a_obs_hi: assert property (p_obs_hi) else $error("obs");
  property p_wake_off;
    (!deep_sleep_i) [*3] |=> !wake_o;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake off");
  property p_wake_on;
    (deep_sleep_i && |(wakeup_input_pins_i & wake_en_i)) [*4] |=> wake_o;
  endproperty
  a_wake_on: assert property (p_wake_on) else $error("wake on");
endmodule : scg_clock_gen_chk
bind scg_clock_gen scg_clock_gen_chk u_chk (.clk_i, .resetn_i, .cfg_upd_i,
  .rc_osc_i, .pll_in_o,
  .wakeup_input_pins_i, .wake_en_i, .deep_sleep_i, .main_clk_o,
  .gated_clk_o, .uart_clk_o, .clock_observation_pin_o, .wake_o);
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the clock generation block
// assumes the edge model as peripherals; oscillators from clk_i counts
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import scg_pkg::*;
  logic clk_i = 0, resetn_i = 0, cfg_upd_i = 0, deep_sleep_i = 0;
  logic rc_osc_i = 0, sys_osc_i = 0, wd_osc_i = 0, pll_out_i = 0;
  logic [WAKE_N-1:0] wakeup_input_pins_i = '0, wake_en_i = '0;
  scg_cfg_t cfg_i = '0;
  logic pll_in_o, main_clk_o, uart_clk_o, wd_clk_o, ssp_clk_o, obs_o, wake_o;
  logic [GATE_W-1:0] gated_clk_o;
  logic [21:0][15:0] cnt, base;
  int cyc = 0, err_total = 0, checked = 0;
  int mexp[4] = '{60, 40, 24, 80};
  int oexp[4] = '{30, 20, 12, 40};
  initial forever #20 clk_i = ~clk_i;
  // periods 8, 12, 20 and 6 cycles: all slower than clk_i/2
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    rc_osc_i <= (cyc % 8) < 4;
    sys_osc_i <= (cyc % 12) < 6;
    wd_osc_i <= (cyc % 20) < 10;
    pll_out_i <= (cyc % 6) < 3;
  end
  scg_clock_gen u_dut (.clk_i, .resetn_i, .cfg_i, .cfg_upd_i, .rc_osc_i,
    .sys_osc_i, .wd_osc_i, .pll_out_i, .wakeup_input_pins_i, .wake_en_i,
    .deep_sleep_i, .pll_in_o, .main_clk_o, .gated_clk_o, .uart_clk_o,
    .wd_clk_o, .ssp_clk_o, .clock_observation_pin_o(obs_o), .wake_o);
  scg_edge_model #(.N(22)) u_model (.clk_i, .cnt_o(cnt),
    .clks_i({obs_o, ssp_clk_o, wd_clk_o, uart_clk_o, main_clk_o,
             gated_clk_o}));
  task automatic stop_test();
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  // edge counts may be off by one at the window ends
  task automatic chk(string nm, int exp, int idx);
    int got;
    got = int'(cnt[idx] - base[idx]);
    checked++;
    if (got < exp - 1 || got > exp + 1)
    begin
      err_total++;
      $display("Error %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk
  task automatic chk_b(string nm, logic exp, logic got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_b
  task automatic apply(scg_cfg_t c);
    cfg_i <= c;
    cfg_upd_i <= 1'b1;
    @(posedge clk_i);
    cfg_upd_i <= 1'b0;
    repeat (100) @(posedge clk_i);
    base = cnt;
    repeat (480) @(posedge clk_i);
  endtask : apply
  task automatic pll_in(logic sys);
    repeat (8)
    begin
      @(negedge clk_i);
      chk_b("pll_in", sys ? sys_osc_i : rc_osc_i, pll_in_o);
    end
    // hand back on a rising edge, where the next driver starts
    @(posedge clk_i);
  endtask : pll_in
  task automatic t_reset();
    base = cnt;
    repeat (480) @(posedge clk_i);
    for (int i = 0; i < GATE_W; i++)
      chk("gate", GATE_RST[i] ? 60 : 0, i);
    chk("main", 60, 17);
    for (int i = 18; i < 22; i++)
      chk("div", 0, i);
    pll_in(1'b0);
  endtask : t_reset
  task automatic t_div();
    scg_cfg_t c;
    c = '0;
    c.pll_src_sys = 1'b1;
    c.uart_div = 8'h01;
    c.wd_div = 8'h02;
    c.ssp_div = 8'h03;
    c.obs_div = 8'h01;
    c.gate = '1;
    apply(c);
    chk("uart", 30, 18);
    chk("wd", 15, 19);
    chk("ssp", 10, 20);
    chk("obs", 30, 21);
    pll_in(1'b1);
  endtask : t_div
  task automatic t_sel();
    scg_cfg_t c;
    c = '0;
    c.pll_src_sys = 1'b1;
    c.obs_div = 8'h01;
    for (int s = 0; s < 4; s++)
    begin
      c.main_sel = scg_main_sel_t'(s);
      c.obs_sel = scg_obs_sel_t'(s);
      c.gate = s[0] ? 17'h0aaaa : 17'h15555;
      apply(c);
      chk("main", mexp[s], 17);
      chk("obs", oexp[s], 21);
      for (int i = 0; i < GATE_W; i++)
        chk("gate", c.gate[i] ? mexp[s] : 0, i);
    end
  endtask : t_sel
  task automatic t_wake();
    deep_sleep_i <= 1'b1;
    wake_en_i <= 11'h400;
    wakeup_input_pins_i <= 11'h008;
    repeat (6) @(posedge clk_i);
    chk_b("wake", 1'b0, wake_o);
    wakeup_input_pins_i <= 11'h400;
    for (int i = 0; i < 10 && wake_o !== 1'b1; i++)
      @(posedge clk_i);
    chk_b("wake", 1'b1, wake_o);
    if (wake_o !== 1'b1)
      stop_test();
    deep_sleep_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk_b("wake", 1'b0, wake_o);
  endtask : t_wake
  initial
  begin
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t_reset();
    t_div();
    t_sel();
    t_wake();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
